// ---- common/lbrc_pkg.sv ----
package lbrc_pkg;
    // Command byte layout
    localparam int        CMD_CONT_BIT     = 7;
    localparam logic [3:0] CMD_BLINK_PAT   = 4'hE;
    // Mode-set is bits 6:5 = 10; bit 4 is a don't-care
    localparam logic [1:0] CMD_MODE_PAT    = 2'h2;
    localparam int        BLINK_AB_BIT     = 2;
    localparam int        MODE_E_BIT       = 3;
    localparam int        MODE_B_BIT       = 2;
    localparam logic [3:0] CMD_BANK_PAT    = 4'hF;

    // Drive mode encodings
    localparam logic [1:0] DRV_STATIC      = 2'h1;
    localparam logic [1:0] DRV_MUX2        = 2'h2;
    localparam logic [1:0] DRV_MUX3        = 2'h3;
    localparam logic [1:0] DRV_MUX4        = 2'h0;

    // Blink rate encodings
    localparam logic [1:0] RATE_OFF        = 2'h0;

    // Reset values
    localparam logic [1:0] RST_DRIVE_MODE  = 2'h0;
    localparam logic       RST_BIAS_HALF   = 1'b0;
    localparam logic       RST_DISP_EN     = 1'b0;
    localparam logic       RST_ALT_BANK    = 1'b0;
    localparam logic [1:0] RST_RATE        = 2'h0;
    localparam logic [5:0] RST_DATA_PTR    = 6'h00;
    localparam logic [2:0] RST_SUBADDR     = 3'h0;
    localparam logic       RST_BANK_SEL    = 1'b0;
    localparam logic       RST_BLANK       = 1'b1;
    localparam logic [2:0] RST_BACKPLANES  = 3'h4;
    localparam logic       RST_CONT        = 1'b0;

    // Blink divider ratios in device clocks per full blink period
    localparam int        BLINK_DIV_1      = 768;
    localparam int        BLINK_DIV_2      = 1536;
    localparam int        BLINK_DIV_3      = 3072;
    localparam int        BLINK_CNT_W      = 12;
    localparam logic [BLINK_CNT_W-1:0] HALF_1 = 12'(BLINK_DIV_1 / 2 - 1);
    localparam logic [BLINK_CNT_W-1:0] HALF_2 = 12'(BLINK_DIV_2 / 2 - 1);
    localparam logic [BLINK_CNT_W-1:0] HALF_3 = 12'(BLINK_DIV_3 / 2 - 1);

    localparam int        NUM_SEG          = 40;
    localparam int        NUM_BP           = 4;

    typedef enum logic [1:0] {
        LBRC_PH_ON  = 2'b01,
        LBRC_PH_OFF = 2'b10
    } lbrc_phase_type;
endpackage

// ---- common/lbrc_blink_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface lbrc_blink_if;
    logic [1:0] rate;
    logic       tick;
    logic       phase_off;
    modport gen (input rate, output tick, output phase_off);
    modport ctl (output rate, input tick, input phase_off);
endinterface
`default_nettype wire

// ---- logic/lbrc_blink_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbrc_blink_gen (
    input  wire logic     mclk,
    input  wire logic     reset,
    lbrc_blink_if.gen     bl
);
    logic [lbrc_pkg::BLINK_CNT_W-1:0] cnt_reg;
    logic                             off_reg;
    logic                             tick_reg;
    logic [lbrc_pkg::BLINK_CNT_W-1:0] half_limit;
    wire                              at_half;
    wire                              running;

    // Half-period terminal count per rate setting
    always_comb begin
        case (bl.rate)
            2'h1:    half_limit = lbrc_pkg::HALF_1;
            2'h2:    half_limit = lbrc_pkg::HALF_2;
            2'h3:    half_limit = lbrc_pkg::HALF_3;
            default: half_limit = lbrc_pkg::HALF_1;
        endcase
    end

    assign running = (bl.rate != lbrc_pkg::RATE_OFF);
    // Terminal test uses >= so a shorter rate selected mid-count cannot overrun
    assign at_half = running && (cnt_reg >= half_limit);

    // Divider runs only while a blink rate is selected, phase toggles every half period
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_reg  <= '0;
            off_reg  <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= (!running || at_half) ? '0 : cnt_reg + 1'b1;
            off_reg  <= running ? (off_reg ^ at_half) : 1'b0;
            tick_reg <= at_half;
        end
    end

    assign bl.tick      = tick_reg;
    assign bl.phase_off = off_reg;

    // ==================================================================
    // Checks
    // ==================================================================
    // Gap is only trusted once a whole half period ran at one unchanged rate
    logic [lbrc_pkg::BLINK_CNT_W-1:0] gap_reg;
    logic                             gap_ok_reg;
    logic [1:0]                       rate_seen_reg;
    logic [lbrc_pkg::BLINK_CNT_W-1:0] gap_expect;

    assign gap_expect = (rate_seen_reg == 2'h3) ? 12'(lbrc_pkg::BLINK_DIV_3 / 2 - 1)
                      : (rate_seen_reg == 2'h2) ? 12'(lbrc_pkg::BLINK_DIV_2 / 2 - 1)
                      : 12'(lbrc_pkg::BLINK_DIV_1 / 2 - 1);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            gap_reg       <= '0;
            gap_ok_reg    <= 1'b0;
            rate_seen_reg <= lbrc_pkg::RATE_OFF;
        end else begin
            gap_reg       <= tick_reg ? '0 : gap_reg + 1'b1;
            gap_ok_reg    <= (bl.rate == rate_seen_reg) && (tick_reg || gap_ok_reg);
            rate_seen_reg <= bl.rate;
        end
    end

    property p_half_period;
        @(posedge mclk) disable iff (reset)
        tick_reg && gap_ok_reg |-> gap_reg == gap_expect;
    endproperty
    a_half_period: assert property (p_half_period) else $error("half period wrong");

    property p_phase_toggle;
        @(posedge mclk) disable iff (reset)
        tick_reg |-> off_reg != $past(off_reg);
    endproperty
    a_phase_toggle: assert property (p_phase_toggle) else $error("phase not toggled");

    property p_idle_phase;
        @(posedge mclk) disable iff (reset)
        bl.rate == lbrc_pkg::RATE_OFF |=> !off_reg;
    endproperty
    a_idle_phase: assert property (p_idle_phase) else $error("phase not cleared");
endmodule
`default_nettype wire

// ---- logic/lbrc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbrc_ctrl (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic        cmd_valid,
    input  wire logic        ptr_load,
    input  wire logic [5:0]  ptr_value,
    input  wire logic        subaddr_load,
    input  wire logic [2:0]  subaddr_value,
    output logic [1:0]       drive_mode,
    output logic             bias_half,
    output logic [2:0]       active_backplanes,
    output logic             display_en,
    output logic             blink_alt_bank_sel,
    output logic [1:0]       blink_rate_sel,
    output logic             in_bank_sel,
    output logic             out_bank_sel,
    output logic [5:0]       data_ptr,
    output logic [2:0]       subaddr_cnt,
    output logic             output_blank,
    output logic             cmd_continue
);
    // ==================================================================
    // Command decode
    // ==================================================================
    wire is_blink = cmd_valid && (cmd_byte[6:3] == lbrc_pkg::CMD_BLINK_PAT);
    wire is_mode  = cmd_valid && (cmd_byte[6:5] == lbrc_pkg::CMD_MODE_PAT);
    wire is_bank  = cmd_valid && (cmd_byte[6:3] == lbrc_pkg::CMD_BANK_PAT)
                    && !cmd_byte[2];

    logic [1:0] drive_reg;
    logic       bias_reg;
    logic       en_reg;
    logic       ab_reg;
    logic [1:0] rate_reg;
    logic       in_bank_reg;
    logic       out_bank_reg;
    logic [5:0] ptr_reg;
    logic [2:0] sub_reg;
    logic       blank_reg;
    logic       shown_bank_reg;
    logic [2:0] nbp_reg;
    logic       cont_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            drive_reg <= lbrc_pkg::RST_DRIVE_MODE;
            bias_reg  <= lbrc_pkg::RST_BIAS_HALF;
            en_reg    <= lbrc_pkg::RST_DISP_EN;
        end else if (is_mode) begin
            drive_reg <= cmd_byte[1:0];
            bias_reg  <= cmd_byte[lbrc_pkg::MODE_B_BIT];
            en_reg    <= cmd_byte[lbrc_pkg::MODE_E_BIT];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ab_reg   <= lbrc_pkg::RST_ALT_BANK;
            rate_reg <= lbrc_pkg::RST_RATE;
        end else if (is_blink) begin
            ab_reg   <= cmd_byte[lbrc_pkg::BLINK_AB_BIT];
            rate_reg <= cmd_byte[1:0];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            in_bank_reg  <= lbrc_pkg::RST_BANK_SEL;
            out_bank_reg <= lbrc_pkg::RST_BANK_SEL;
        end else if (is_bank) begin
            in_bank_reg  <= cmd_byte[1];
            out_bank_reg <= cmd_byte[0];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ptr_reg <= lbrc_pkg::RST_DATA_PTR;
            sub_reg <= lbrc_pkg::RST_SUBADDR;
        end else begin
            if (ptr_load)
                ptr_reg <= ptr_value;
            if (subaddr_load)
                sub_reg <= subaddr_value;
        end
    end

    // ==================================================================
    // Blink generator
    // ==================================================================
    lbrc_blink_if bl ();
    assign bl.rate = rate_reg;

    lbrc_blink_gen lbrc_blink_gen_inst (
        .mclk  (mclk),
        .reset (reset),
        .bl    (bl)
    );

    // Alternate bank blinking only exists with static or duplex drive
    wire mux_low    = (drive_reg == lbrc_pkg::DRV_STATIC) || (drive_reg == lbrc_pkg::DRV_MUX2);
    wire alt_active = ab_reg && mux_low;
    wire normal_off = !alt_active && (rate_reg != lbrc_pkg::RATE_OFF)
                      && bl.phase_off;
    wire blank_next = !en_reg || normal_off;
    wire swap_bank  = alt_active && (rate_reg != lbrc_pkg::RATE_OFF) && bl.phase_off;
    wire shown_next = out_bank_reg ^ swap_bank;

    logic [2:0] nbp_next;
    always_comb begin
        case (drive_reg)
            lbrc_pkg::DRV_STATIC: nbp_next = 3'h1;
            lbrc_pkg::DRV_MUX2:   nbp_next = 3'h2;
            lbrc_pkg::DRV_MUX3:   nbp_next = 3'h3;
            default:              nbp_next = 3'h4;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            blank_reg      <= lbrc_pkg::RST_BLANK;
            shown_bank_reg <= lbrc_pkg::RST_BANK_SEL;
            nbp_reg        <= lbrc_pkg::RST_BACKPLANES;
            cont_reg       <= lbrc_pkg::RST_CONT;
        end else begin
            blank_reg      <= blank_next;
            shown_bank_reg <= shown_next;
            nbp_reg        <= nbp_next;
            cont_reg       <= cmd_valid ? cmd_byte[lbrc_pkg::CMD_CONT_BIT] : cont_reg;
        end
    end

    // ==================================================================
    // Outputs
    // ==================================================================
    assign drive_mode         = drive_reg;
    assign bias_half          = bias_reg;
    assign active_backplanes  = nbp_reg;
    assign display_en         = en_reg;
    assign blink_alt_bank_sel = ab_reg;
    assign blink_rate_sel     = rate_reg;
    assign in_bank_sel        = in_bank_reg;
    assign out_bank_sel       = shown_bank_reg;
    assign data_ptr           = ptr_reg;
    assign subaddr_cnt        = sub_reg;
    assign output_blank       = blank_reg;
    assign cmd_continue       = cont_reg;

    // ==================================================================
    // Checks
    // ==================================================================
    property p_blank_when_disabled;
        @(posedge mclk) disable iff (reset) !en_reg |=> blank_reg;
    endproperty
    a_blank_when_disabled: assert property (p_blank_when_disabled) else $error("not blank");

    property p_blink_decode;
        @(posedge mclk) disable iff (reset)
        (cmd_valid && cmd_byte[6:3] == 4'hE) |=> (rate_reg == $past(cmd_byte[1:0]));
    endproperty
    a_blink_decode: assert property (p_blink_decode) else $error("rate not taken");

    property p_ab_decode;
        @(posedge mclk) disable iff (reset)
        (cmd_valid && cmd_byte[6:3] == 4'hE) |=> (ab_reg == $past(cmd_byte[2]));
    endproperty
    a_ab_decode: assert property (p_ab_decode) else $error("blink mode not taken");

    property p_no_swap_high_mux;
        @(posedge mclk) disable iff (reset)
        (drive_reg == 2'h0 || drive_reg == 2'h3) && $stable(drive_reg)
        && !is_bank |=> (shown_bank_reg == out_bank_reg);
    endproperty
    a_no_swap_high_mux: assert property (p_no_swap_high_mux) else $error("bank swapped");

    property p_swap_on_phase;
        @(posedge mclk) disable iff (reset)
        alt_active && rate_reg != 2'h0 && bl.phase_off |=> (shown_bank_reg != $past(out_bank_reg));
    endproperty
    a_swap_on_phase: assert property (p_swap_on_phase) else $error("no swap");

    property p_normal_blank;
        @(posedge mclk) disable iff (reset)
        en_reg && !alt_active && rate_reg != 2'h0 && bl.phase_off |=> blank_reg;
    endproperty
    a_normal_blank: assert property (p_normal_blank) else $error("no blink blank");

    property p_backplanes;
        @(posedge mclk) disable iff (reset)
        drive_reg == 2'h1 |=> nbp_reg == 3'h1;
    endproperty
    a_backplanes: assert property (p_backplanes) else $error("backplane count");

    property p_reset_state;
        @(posedge mclk) $fell(reset) |-> blank_reg && drive_reg == 2'h0 && !en_reg
            && rate_reg == 2'h0 && ptr_reg == 6'h00 && sub_reg == 3'h0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state");

    c_alt_swap:   cover property (@(posedge mclk) disable iff (reset) alt_active ##1 bl.tick);
    c_normal:     cover property (@(posedge mclk) disable iff (reset) normal_off && en_reg);
    c_rate3_tick: cover property (@(posedge mclk) disable iff (reset) rate_reg == 2'h3 && bl.tick);
endmodule
`default_nettype wire

// ---- sim/lbrc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host controller model
module lbrc_host_model #(
    parameter int POR_WAIT = 40000
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    output logic [7:0]      cmd_byte,
    output logic            cmd_valid,
    output logic            ptr_load,
    output logic [5:0]      ptr_value,
    output logic            subaddr_load,
    output logic [2:0]      subaddr_value
);
    int por_cnt = 0;
    initial begin
        {cmd_byte, cmd_valid, ptr_load, ptr_value, subaddr_load, subaddr_value} = '0;
    end
    // Counts from power-on only; a later reset is not a power cycle
    always @(posedge mclk) if (!reset && por_cnt < POR_WAIT) por_cnt <= por_cnt + 1;
    task automatic send(input logic [7:0] b);
        while (por_cnt < POR_WAIT) @(posedge mclk);
        @(negedge mclk);
        cmd_byte = b;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        // Idle bus never repeats the old byte, so stale sampling shows up
        cmd_byte = ~b;
    endtask
    task automatic load(input logic [5:0] p, input logic [2:0] s);
        @(negedge mclk);
        {ptr_load, ptr_value, subaddr_load, subaddr_value} = {1'b1, p, 1'b1, s};
        @(negedge mclk);
        {ptr_load, ptr_value, subaddr_load, subaddr_value} = {1'b0, ~p, 1'b0, ~s};
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_lbrc_blink_reset_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module tb_lbrc_blink_reset_control;
    logic mclk, reset, cmd_valid, ptr_load, subaddr_load;
    logic [7:0] cmd_byte;
    logic [5:0] ptr_value, data_ptr;
    logic [2:0] subaddr_value, subaddr_cnt, active_backplanes;
    logic [1:0] drive_mode, blink_rate_sel;
    logic bias_half, display_en, blink_alt_bank_sel, in_bank_sel, out_bank_sel;
    logic output_blank, cmd_continue;
    int miscompares = 0;
    int cmp_count = 0;
    lbrc_host_model #(.POR_WAIT(40000)) lbrc_host_model_inst (.mclk(mclk), .reset(reset),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .ptr_load(ptr_load),
        .ptr_value(ptr_value), .subaddr_load(subaddr_load), .subaddr_value(subaddr_value));
    lbrc_ctrl lbrc_ctrl_inst (.mclk(mclk), .reset(reset), .cmd_byte(cmd_byte),
        .cmd_valid(cmd_valid), .ptr_load(ptr_load), .ptr_value(ptr_value),
        .subaddr_load(subaddr_load), .subaddr_value(subaddr_value), .drive_mode(drive_mode),
        .bias_half(bias_half), .active_backplanes(active_backplanes), .display_en(display_en),
        .blink_alt_bank_sel(blink_alt_bank_sel), .blink_rate_sel(blink_rate_sel),
        .in_bank_sel(in_bank_sel), .out_bank_sel(out_bank_sel), .data_ptr(data_ptr),
        .subaddr_cnt(subaddr_cnt), .output_blank(output_blank), .cmd_continue(cmd_continue));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        lbrc_host_model_inst.send(b);
    endtask
    // ==========
    // Scenarios
    task automatic t_reset;
        `CHK("output_blank", 1'b1, output_blank)
        `CHK("drive_mode", 2'h0, drive_mode)
        `CHK("bias_half", 1'b0, bias_half)
        `CHK("active_backplanes", 3'h4, active_backplanes)
        `CHK("rate", 2'h0, blink_rate_sel)
        `CHK("alt_bank", 1'b0, blink_alt_bank_sel)
        `CHK("banks", 2'h0, {in_bank_sel, out_bank_sel})
        `CHK("ptr_sub", 9'h000, {data_ptr, subaddr_cnt})
        `CHK("display_en", 1'b0, display_en)
    endtask
    // Half period measured on the second full half, since the first may be cut short
    task automatic half_gap(input bit alt, output int n);
        logic v;
        for (int k = 0; k < 3; k++) begin
            v = alt ? out_bank_sel : output_blank;
            n = 0;
            while ((alt ? out_bank_sel : output_blank) === v && n < 4000) begin
                @(negedge mclk);
                n++;
            end
        end
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            send(8'h48 | 8'(m) | 8'(m % 2 * 4));
            @(negedge mclk);
            `CHK("drive_mode", 2'(m), drive_mode)
            `CHK("bias_half", 1'(m % 2), bias_half)
            `CHK("active_backplanes", 3'(m == 0 ? 4 : m), active_backplanes)
            `CHK("output_blank", 1'b0, output_blank)
        end
    endtask
    task automatic t_enable;
        send(8'h40);
        @(negedge mclk);
        `CHK("display_en", 1'b0, display_en)
        `CHK("output_blank", 1'b1, output_blank)
        send(8'h48);
        @(negedge mclk);
        `CHK("output_blank", 1'b0, output_blank)
    endtask
    task automatic t_blink;
        int n;
        for (int r = 1; r < 4; r++) begin
            send(8'h70 | 8'(r));
            `CHK("rate", 2'(r), blink_rate_sel)
            half_gap(1'b0, n);
            `CHK("half_period", 384 << (r - 1), n)
        end
        send(8'h70);
        repeat (2) @(negedge mclk);
        half_gap(1'b0, n);
        `CHK("blink_off", 4000, n)
    endtask
    task automatic t_alt;
        int n;
        send(8'h49);
        send(8'hF5);
        `CHK("alt_bank", 1'b1, blink_alt_bank_sel)
        `CHK("continue", 1'b1, cmd_continue)
        half_gap(1'b1, n);
        `CHK("bank_swap", 384, n)
        `CHK("no_blank", 1'b0, output_blank)
        send(8'h4B);
        half_gap(1'b0, n);
        `CHK("mux3_normal", 384, n)
        `CHK("no_swap", 1'b0, out_bank_sel)
        // No alternate bank here, so the host re-points the pointer to rewrite elements
        lbrc_host_model_inst.load(6'h15, 3'h0);
        `CHK("rewrite_ptr", 6'h15, data_ptr)
    endtask
    task automatic t_bank;
        send(8'h70);
        send(8'h49);
        send(8'h7B);
        @(negedge mclk);
        `CHK("banks", 2'h3, {in_bank_sel, out_bank_sel})
        send(8'h65);
        `CHK("ignored", 3'h1, {blink_rate_sel, in_bank_sel})
        lbrc_host_model_inst.load(6'h27, 3'h5);
        `CHK("ptr_sub", {6'h27, 3'h5}, {data_ptr, subaddr_cnt})
        @(negedge mclk);
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        t_reset();
        reset = 1'b0;
    endtask
    initial begin
        reset = 1'b1;
        repeat (16) @(negedge mclk);
        t_reset();
        reset = 1'b0;
        t_modes();
        t_enable();
        t_blink();
        t_alt();
        t_bank();
        end_sim();
    end
    initial begin
        repeat (95000) @(posedge mclk);
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
